// ### logic/stc_pkg.sv
// Constants and carrier types for the stack channel card
package stc_pkg;
	// Memory geometry
	localparam int          MEM_DEPTH = 1024;
	localparam int          AW        = 10;
	localparam int          DW        = 8;
	localparam int          BUF_DEPTH = 2;
	// Byte split of pointer and counter
	localparam int          LO_MSB    = 7;
	localparam int          HI_MSB    = 9;
	localparam int          HI_LSB    = 8;
	localparam int          HI_W      = 2;
	// Reset and step values
	localparam logic [9:0]  PTR_RST   = 10'h000;
	localparam logic [9:0]  CNT_ZERO  = 10'h000;
	localparam logic [9:0]  STEP_ONE  = 10'h001;
	localparam logic [7:0]  DOUT_IDLE = 8'hFF;
	localparam logic [7:0]  BYTE_ZERO = 8'h00;
	// Direction pin level that means write into the memory
	localparam logic        DIR_WRITE = 1'b0;
	// Default stack addresses (group 0 left for wide input cards)
	localparam logic [2:0]  GROUP_DEF = 3'h6;
	localparam logic [4:0]  OUT_DEF   = 5'h06;
	// Receipt timing at 125 MHz
	localparam int          CLK_NS      = 8;
	localparam int          RECEIPT_NS  = 600;
	localparam int          REPLY_NS    = 500;
	localparam int          RECEIPT_CYC = (RECEIPT_NS + CLK_NS - 1) / CLK_NS;
	localparam int          REPLY_CYC   = REPLY_NS / CLK_NS;
	localparam logic [6:0]  RC_ZERO     = 7'h00;
	localparam logic [6:0]  RC_ONE      = 7'h01;
	localparam logic [6:0]  RC_LAST     = 7'(RECEIPT_CYC - 1);

	// Processor instruction strobes on the I/O bus
	typedef struct packed {
		logic       in_stb;
		logic [2:0] in_group;
		logic       out_stb;
		logic [4:0] out_addr;
		logic [7:0] out_data;
	} stc_cpu_req_t;

	// Loads from the interfaces wired to pointer and counter
	typedef struct packed {
		logic       ptr_lo;
		logic       ptr_hi;
		logic       cnt_lo;
		logic       cnt_hi;
		logic [7:0] data;
	} stc_load_t;

	// Channel handshake states
	typedef enum {CH_IDLE, CH_RECEIPT} stc_ch_state_t;
endpackage

// ### logic/stc_stack_channel.sv
// Stack channel: dual-port scratch-pad RAM with pointer and word counter
//
// Contract
// - One RAM, two ports, one access at once
// - Peripheral port: eight in, eight out
// - Pointer advances on every transfer, either port
// - Peripheral request answered by device receipt
// - Counter decrements per transfer, stops at zero
// - Counter load starts transfer, selected direction
// - Direction low writes, high reads memory
// - Counter zero drives end output low
// - Input cycles decode only group address
// - Processor input: decrement pointer, then read
// - Processor output: write, then increment pointer
// - Pointer interface write loads pointer byte
// - Pointer and counter split high/low byte
// - Link: data in/out, request, receipt, end
// - Stack access clears counter, aborting channel
// - Receipt 0.6 us low, within 0.5 us
// - Idle-time request held as level
`timescale 1ns/1ps

// Two-entry word buffer between peripheral and memory
module stc_word_buf
	import stc_pkg::*;
#(
	parameter int W     = DW,
	parameter int DEPTH = BUF_DEPTH
)(
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int IW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [IW-1:0] I_ONE  = IW'(1);
	localparam logic [IW-1:0] I_LAST = IW'(DEPTH - 1);
	localparam logic [CW-1:0] C_ONE  = CW'(1);
	localparam logic [CW-1:0] C_FULL = CW'(DEPTH);

	logic [W-1:0]  ent_r [DEPTH];   // Storage entries
	logic [IW-1:0] wr_r, wr_nxt;    // Fill index
	logic [IW-1:0] rd_r, rd_nxt;    // Drain index
	logic [CW-1:0] cnt_r, cnt_nxt;  // Occupancy
	logic          push, pop;

	// Honest full and empty from occupancy
	always_comb
	begin
		in_ready  = cnt_r != C_FULL;
		out_valid = cnt_r != '0;
		out_data  = ent_r[rd_r];
		push      = in_valid & in_ready;
		pop       = out_valid & out_ready;
		wr_nxt    = push ? ((wr_r == I_LAST) ? '0 : wr_r + I_ONE) : wr_r;
		rd_nxt    = pop ? ((rd_r == I_LAST) ? '0 : rd_r + I_ONE) : rd_r;
		cnt_nxt   = cnt_r;
		if (push & ~pop)
			cnt_nxt = cnt_r + C_ONE;
		else if (pop & ~push)
			cnt_nxt = cnt_r - C_ONE;
	end

	// Index registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_r  <= '0;
			rd_r  <= '0;
			cnt_r <= '0;
		end
		else
		begin
			wr_r  <= wr_nxt;
			rd_r  <= rd_nxt;
			cnt_r <= cnt_nxt;
			if (push) // Entries need no reset
				ent_r[wr_r] <= in_data;
		end
	end
endmodule

// Top of the stack channel card
module stc_stack_channel
	import stc_pkg::*;
#(
	parameter logic [2:0] STACK_GROUP = GROUP_DEF,
	parameter logic [4:0] STACK_OUT   = OUT_DEF
)(
	input  wire logic          clock,
	input  wire logic          rst,
	input  wire stc_cpu_req_t  cpu_req,
	input  wire stc_load_t     reg_load,
	output logic [7:0]         processor_read_bus,
	output logic [9:0]         pointer_value,
	output logic [9:0]         counter_value,
	input  wire logic [7:0]    peripheral_data_in_n,
	output logic [7:0]         peripheral_data_out_n,
	input  wire logic          exchange_request_n,
	output logic               exchange_receipt_n,
	input  wire logic          transfer_dir,
	output logic               block_end_flag_n
);
	logic [DW-1:0]   mem_r [MEM_DEPTH];     // Scratch-pad storage
	logic [9:0]      s1_r, s2_r;            // Pin synchronisers
	logic [7:0]      din_s;                 // Synced peripheral data
	logic            req_s, dir_s;          // Synced request, direction
	logic            req_prev_r, act_prev_r; // Request, active history
	logic            pend_r, pend_nxt;      // Request waiting
	logic [9:0]      ptr_r, ptr_nxt;        // Memory pointer
	logic [9:0]      cnt_r, cnt_nxt;        // Word counter
	logic            dir_r, dir_nxt;        // Direction caught at load
	logic [6:0]      rc_r, rc_nxt;          // Receipt length count
	stc_ch_state_t   st_r, st_nxt;          // Handshake state
	logic [7:0]      rbus_r, rbus_nxt;      // Processor read data
	logic [7:0]      dout_r, dout_nxt;      // Peripheral out data
	logic            rcpt_n_r, end_n_r;     // Registered link outputs
	logic            proc_in, proc_out;     // Stack accesses
	logic            proc_any, ptr_ld, mem_busy, mem_we;
	logic            active, pend_set, chan_go, chan_rd;
	logic            buf_push, buf_in_ready, buf_out_valid, drain;
	logic [7:0]      buf_data, mem_wdata;

	// Every link input pin passes two flops before any logic reads it
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s1_r <= '1; // Idle levels: no request, read
			s2_r <= '1;
		end
		else
		begin
			s1_r <= {transfer_dir, exchange_request_n, peripheral_data_in_n};
			s2_r <= s1_r;
		end
	end
	assign din_s = s2_r[7:0];
	assign req_s = s2_r[8];
	assign dir_s = s2_r[9];

	// Write-path buffer: holds peripheral words while the processor owns RAM
	stc_word_buf #(.W(DW), .DEPTH(BUF_DEPTH)) u_buf (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (buf_push),
		.in_ready  (buf_in_ready),
		.in_data   (~din_s),
		.out_valid (buf_out_valid),
		.out_ready (~mem_busy),
		.out_data  (buf_data)
	);

	// Arbitration, handshake and next-state logic
	always_comb
	begin
		// Inputs decode group only; outputs decode full address
		proc_in  = cpu_req.in_stb && cpu_req.in_group == STACK_GROUP;
		proc_out = cpu_req.out_stb && cpu_req.out_addr == STACK_OUT;
		proc_any = proc_in | proc_out;
		ptr_ld   = reg_load.ptr_lo | reg_load.ptr_hi;
		// Processor side owns the RAM whenever it asks
		mem_busy = proc_any | ptr_ld;
		active   = cnt_r != CNT_ZERO;
		// Short pulse edge, or a level already low when channel opens
		pend_set = (req_prev_r & ~req_s)
			| (active & ~act_prev_r & ~req_s);
		// Write needs buffer room; read needs the RAM and no stale words
		chan_go = st_r == CH_IDLE && pend_r && active
			&& ((dir_r == DIR_WRITE) ? buf_in_ready
			: (~mem_busy & ~buf_out_valid));
		buf_push = chan_go & (dir_r == DIR_WRITE);
		chan_rd  = chan_go & (dir_r != DIR_WRITE);
		drain    = buf_out_valid & ~mem_busy;
		// A new request in the service cycle is kept
		pend_nxt = pend_set | (pend_r & ~chan_go);

		// Receipt pulse sequencer
		st_nxt = st_r;
		rc_nxt = rc_r;
		case (st_r)
			CH_IDLE:
			begin
				if (chan_go)
				begin
					st_nxt = CH_RECEIPT;
					rc_nxt = RC_ZERO;
				end
			end
			CH_RECEIPT:
			begin
				// Fixed low time, then back to idle
				if (rc_r == RC_LAST)
					st_nxt = CH_IDLE;
				else
					rc_nxt = rc_r + RC_ONE;
			end
			default:
				st_nxt = CH_IDLE;
		endcase

		// Counter: stack access aborts, loads beat the decrement
		cnt_nxt = cnt_r;
		dir_nxt = dir_r;
		if (proc_any)
			cnt_nxt = CNT_ZERO;
		else
		begin
			if (chan_go)
				cnt_nxt = cnt_r - STEP_ONE;
			if (reg_load.cnt_lo)
				cnt_nxt[LO_MSB:0] = reg_load.data;
			if (reg_load.cnt_hi)
				cnt_nxt[HI_MSB:HI_LSB] = reg_load.data[HI_W-1:0];
			if (reg_load.cnt_lo | reg_load.cnt_hi)
				dir_nxt = dir_s;
		end

		// Pointer: load, then processor, then channel; wraps in 10 bits
		ptr_nxt = ptr_r;
		if (ptr_ld)
		begin
			if (reg_load.ptr_lo)
				ptr_nxt[LO_MSB:0] = reg_load.data;
			if (reg_load.ptr_hi)
				ptr_nxt[HI_MSB:HI_LSB] = reg_load.data[HI_W-1:0];
		end
		else if (proc_in)
			ptr_nxt = ptr_r - STEP_ONE;
		else if (proc_out)
			ptr_nxt = ptr_r + STEP_ONE;
		else if (chan_rd | drain)
			ptr_nxt = ptr_r + STEP_ONE;

		// Single RAM write port; input beats output if both strobe
		mem_we    = (proc_out & ~proc_in & ~ptr_ld) | drain;
		mem_wdata = drain ? buf_data : cpu_req.out_data;
		// Input reads the word below the current pointer
		rbus_nxt  = (proc_in & ~ptr_ld) ? mem_r[ptr_r - STEP_ONE] : rbus_r;
		// Link pins are active low
		dout_nxt  = chan_rd ? ~mem_r[ptr_r] : dout_r;
	end

	// Control registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			req_prev_r <= 1'b1;
			act_prev_r <= 1'b0;
			pend_r     <= 1'b0;
			ptr_r      <= PTR_RST;
			cnt_r      <= CNT_ZERO;
			dir_r      <= ~DIR_WRITE;
			st_r       <= CH_IDLE;
			rc_r       <= RC_ZERO;
			rbus_r     <= BYTE_ZERO;
			dout_r     <= DOUT_IDLE;
			rcpt_n_r   <= 1'b1;
			end_n_r    <= 1'b0;
		end
		else
		begin
			req_prev_r <= req_s;
			act_prev_r <= active;
			pend_r     <= pend_nxt;
			ptr_r      <= ptr_nxt;
			cnt_r      <= cnt_nxt;
			dir_r      <= dir_nxt;
			st_r       <= st_nxt;
			rc_r       <= rc_nxt;
			rbus_r     <= rbus_nxt;
			dout_r     <= dout_nxt;
			rcpt_n_r   <= st_nxt != CH_RECEIPT;
			end_n_r    <= cnt_nxt != CNT_ZERO;
			if (mem_we) // RAM itself takes no reset
				mem_r[ptr_r] <= mem_wdata;
		end
	end

	// Outputs, all from flops
	assign processor_read_bus    = rbus_r;
	assign pointer_value         = ptr_r;
	assign counter_value         = cnt_r;
	assign peripheral_data_out_n = dout_r;
	assign exchange_receipt_n    = rcpt_n_r;
	assign block_end_flag_n      = end_n_r;

	// Checks on the design's own behaviour
	one_writer_a: assert property (@(posedge clock) disable iff (rst)
		drain |-> !proc_any && !ptr_ld)
		else $error("channel drain collided with processor access");
	in_predec_a: assert property (@(posedge clock) disable iff (rst)
		proc_in && !ptr_ld |=> ptr_r == $past(ptr_r) - STEP_ONE
			&& rbus_r == mem_r[ptr_r])
		else $error("stack input did not pre-decrement");
	out_postinc_a: assert property (@(posedge clock) disable iff (rst)
		proc_out && !proc_in && !ptr_ld |=> ptr_r == $past(ptr_r) + STEP_ONE
			&& mem_r[$past(ptr_r)] == $past(cpu_req.out_data))
		else $error("stack output did not write then increment");
	abort_clear_a: assert property (@(posedge clock) disable iff (rst)
		proc_any |=> cnt_r == CNT_ZERO && block_end_flag_n == 1'b0)
		else $error("stack access did not clear the counter");
	count_dec_a: assert property (@(posedge clock) disable iff (rst)
		chan_go && !proc_any && !reg_load.cnt_lo && !reg_load.cnt_hi
			|=> cnt_r == $past(cnt_r) - STEP_ONE)
		else $error("counter did not step on transfer");
	stop_zero_a: assert property (@(posedge clock) disable iff (rst)
		cnt_r == CNT_ZERO |-> !chan_go && block_end_flag_n == 1'b0)
		else $error("channel ran with counter at zero");
	receipt_len_a: assert property (@(posedge clock) disable iff (rst)
		$fell(exchange_receipt_n) |-> ##74 !exchange_receipt_n
			##1 exchange_receipt_n)
		else $error("receipt pulse length wrong");
	go_receipt_a: assert property (@(posedge clock) disable iff (rst)
		chan_go |=> !exchange_receipt_n && st_r == CH_RECEIPT)
		else $error("transfer without receipt");
	ptr_load_a: assert property (@(posedge clock) disable iff (rst)
		reg_load.ptr_lo |=> ptr_r[LO_MSB:0] == $past(reg_load.data))
		else $error("pointer low byte not loaded");
	load_start_a: assert property (@(posedge clock) disable iff (rst)
		reg_load.cnt_lo && !proc_any && reg_load.data != BYTE_ZERO
			|=> block_end_flag_n && dir_r == $past(dir_s))
		else $error("counter load did not start channel");
	ptr_wrap_a: assert property (@(posedge clock) disable iff (rst)
		proc_in && !ptr_ld && ptr_r == PTR_RST |=> ptr_r == ~PTR_RST)
		else $error("pointer did not wrap below zero");
endmodule

// ### verification/stc_periph_model.sv
// Fast peripheral model on the far side of the stack channel link
`timescale 1ns/1ps

module stc_periph_model
	import stc_pkg::*;
(
	input  wire logic       clock,
	input  wire logic [31:0] words,
	input  wire logic [7:0] base,
	input  wire logic       exchange_receipt_n,
	input  wire logic [7:0] peripheral_data_out_n,
	output logic            exchange_request_n,
	output logic [7:0]      peripheral_data_in_n,
	output logic [7:0]      rx_word,
	output int              receipts,
	output int              low_width
);
	// One word per request; a cap on words avoids a stray request
	initial
	begin
		exchange_request_n = 1'b1;
		peripheral_data_in_n = 8'h00;
		rx_word = 8'h00;
		receipts = 0;
		low_width = 0;
		forever
		begin
			@(posedge clock);
			if (words == 0)
				receipts = 0;
			else if (receipts < words)
			begin
				// Request held as a level until the receipt
				#1 exchange_request_n = 1'b0;
				peripheral_data_in_n = ~(base + 8'(receipts));
				while (exchange_receipt_n !== 1'b0)
					@(posedge clock);
				rx_word = ~peripheral_data_out_n;
				receipts++;
				// Released lines show the inverse, never a stale word
				#1 exchange_request_n = 1'b1;
				peripheral_data_in_n = ~peripheral_data_in_n;
				// Receipt width measured in cycles
				low_width = 1;
				@(posedge clock);
				while (exchange_receipt_n === 1'b0)
				begin
					low_width++;
					@(posedge clock);
				end
			end
		end
	end
endmodule

// ### verification/stc_stack_channel_tb.sv
// Self-checking bench for the stack channel card
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %h want %h", $time, a, e); end end

module stc_stack_channel_tb
	import stc_pkg::*;
;
	logic         clock;
	logic         rst;
	stc_cpu_req_t cpu_req;
	stc_load_t    reg_load;
	logic [7:0]   rd_bus;
	logic [9:0]   ptr;
	logic [9:0]   cnt;
	logic [7:0]   dout_n;
	logic [7:0]   din_n;
	logic         req_n;
	logic         rcpt_n;
	logic         dir;
	logic         end_n;
	int           words;
	logic [7:0]   base;
	logic [7:0]   rx_word;
	int           receipts;
	int           low_width;
	int           miscompares;
	int           comparisons;

	// Stack group left at its non-zero default
	stc_stack_channel DUT (.clock(clock), .rst(rst), .cpu_req(cpu_req),
		.reg_load(reg_load), .processor_read_bus(rd_bus),
		.pointer_value(ptr), .counter_value(cnt),
		.peripheral_data_in_n(din_n), .peripheral_data_out_n(dout_n),
		.exchange_request_n(req_n), .exchange_receipt_n(rcpt_n),
		.transfer_dir(dir), .block_end_flag_n(end_n));

	stc_periph_model PERIPH (.clock(clock), .words(words), .base(base),
		.exchange_receipt_n(rcpt_n), .peripheral_data_out_n(dout_n),
		.exchange_request_n(req_n), .peripheral_data_in_n(din_n),
		.rx_word(rx_word), .receipts(receipts), .low_width(low_width));

	// 125 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Drive just after the rising edge
	task step;
		@(posedge clock);
		#1;
	endtask

	// One processor stack input or output, one-cycle strobe
	task io(input logic is_in, input logic [2:0] g, input logic [4:0] a,
		input logic [7:0] d);
		step;
		cpu_req = '{is_in, g, !is_in, a, d};
		step;
		cpu_req = '0;
		step;
	endtask

	// Pointer or counter load: {ptr_lo, ptr_hi, cnt_lo, cnt_hi}
	task ld(input logic [3:0] which, input logic [7:0] d);
		step;
		reg_load = stc_load_t'({which, d});
		step;
		reg_load = '0;
		step;
	endtask

	// Bounded wait for the word counter to run out
	task wait_end;
		int i;
		for (i = 0; i < 2000 && cnt !== CNT_ZERO; i++)
			step;
		// Let the last receipt end so its width is complete
		for (i = 0; i < 200 && rcpt_n !== 1'b1; i++)
			step;
		repeat (4) step;
		`CHK(end_n, 1'b0)
	endtask

	task t_reset;
		`CHK({rd_bus, ptr, cnt}, 28'h0000000)
		`CHK({dout_n, rcpt_n, end_n}, 10'h3FE)
		$display("test reset done");
	endtask

	// Processor pushes and pops, with wrap at both ends
	task t_cpu;
		ld(4'b1000, 8'hFF);
		ld(4'b0100, 8'h03);
		`CHK(ptr, 10'h3FF)
		io(1'b0, 3'h0, OUT_DEF, 8'hA5);
		`CHK(ptr, 10'h000)
		io(1'b0, 3'h0, OUT_DEF, 8'h5A);
		`CHK(ptr, 10'h001)
		io(1'b0, 3'h0, 5'h07, 8'h11);
		io(1'b1, 3'h5, 5'h00, 8'h00);
		`CHK(ptr, 10'h001)
		io(1'b1, GROUP_DEF, 5'h1F, 8'h00);
		`CHK({ptr, rd_bus}, {10'h000, 8'h5A})
		io(1'b1, GROUP_DEF, 5'h00, 8'h00);
		`CHK({ptr, rd_bus}, {10'h3FF, 8'hA5})
		$display("test cpu done");
	endtask

	// Peripheral writes three words, processor pops them back
	task t_chan_write;
		int i;
		dir = DIR_WRITE;
		base = 8'h30;
		ld(4'b1100, 8'h10);
		ld(4'b0011, 8'h00);
		ld(4'b0010, 8'h03);
		`CHK({cnt, end_n}, {10'h003, 1'b1})
		words = 3;
		wait_end;
		`CHK(receipts, 3)
		`CHK(low_width, RECEIPT_CYC)
		`CHK(ptr, 10'h013)
		words = 0;
		// Pointer sits at target plus one, as reads pre-decrement
		for (i = 2; i >= 0; i--)
		begin
			io(1'b1, GROUP_DEF, 5'h00, 8'h00);
			`CHK(rd_bus, base + 8'(i))
		end
		$display("test channel write done");
	endtask

	// Peripheral reads three words from the memory
	task t_chan_read;
		dir = 1'b1;
		repeat (4) step;
		ld(4'b0010, 8'h03);
		words = 3;
		wait_end;
		`CHK(receipts, 3)
		`CHK(rx_word, 8'h32)
		`CHK(ptr, 10'h013)
		words = 0;
		$display("test channel read done");
	endtask

	// Stack access aborts a running channel
	task t_abort;
		ld(4'b0011, 8'h01);
		`CHK({cnt, end_n}, {10'h101, 1'b1})
		io(1'b0, 3'h0, OUT_DEF, 8'h77);
		`CHK({cnt, end_n}, {10'h000, 1'b0})
		ld(4'b0010, 8'h05);
		io(1'b1, GROUP_DEF, 5'h00, 8'h00);
		`CHK({cnt, end_n}, {10'h000, 1'b0})
		$display("test abort done");
	endtask

	task results;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		miscompares = 0;
		comparisons = 0;
		rst = 1'b1;
		cpu_req = '0;
		reg_load = '0;
		dir = 1'b1;
		words = 0;
		base = 8'h00;
		repeat (6) @(posedge clock);
		#1 rst = 1'b0;
		t_reset;
		t_cpu;
		t_chan_write;
		t_chan_read;
		t_abort;
		results;
	end

	// Watchdog, far beyond about 600 cycles of tests
	initial
	begin
		#400000;
		miscompares++;
		results;
	end
endmodule
